// ### slpc_pkg.sv
// constants for the sdram low-power state control block
package slpc_pkg;
  localparam int unsigned CLK_MHZ            = 25;
  localparam int unsigned CLK_PERIOD_NS      = 1000 / CLK_MHZ;
  localparam int unsigned SR_EXIT_EXTRA_NS   = 10;
  localparam int unsigned REFRESH_CYCLE_NS   = 350;
  localparam int unsigned SR_EXIT_DELAY_NS   = REFRESH_CYCLE_NS + SR_EXIT_EXTRA_NS;
  localparam int unsigned SR_EXIT_DELAY_CYC  = (SR_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SR_ABORT_DELAY_NS  = 20;
  localparam int unsigned SR_ABORT_DELAY_CYC = (SR_ABORT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SR_LOCK_DELAY_CYC  = 24;
  localparam int unsigned CMD_LAT_CYC        = 3;
  localparam int unsigned DESEL_WIN_CYC      = 4;
  localparam int unsigned PD_EXIT_LAT_CYC    = 3;
  localparam int unsigned OP_BUSY_CYC        = 4;
  localparam int unsigned CNT_W              = 8;
  localparam int unsigned NBANK              = 16;
  localparam int unsigned ABORT_BIT          = 9;
  localparam int unsigned TERM_DIS_BIT       = 5;

  // reg 0x00 rw control, 0x04 ro state
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_STAT  = 4'h4;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
  // ctrl: bit0 abort enable, bit1 termination buffer disable, bit2 cmd latency mode, bit3 parity/geardown on
  localparam int unsigned CTRL_ABORT = 0;
  localparam int unsigned CTRL_TDIS  = 1;
  localparam int unsigned CTRL_CAL   = 2;
  localparam int unsigned CTRL_PARGD = 3;
  localparam logic [3:0] CTRL_RESET  = 4'h0;

  typedef enum logic [2:0]
  {
    SLPC_IDLE    = 3'b000,
    SLPC_SREF    = 3'b001,
    SLPC_SR_EXIT = 3'b010,
    SLPC_PD_WIN  = 3'b011,
    SLPC_PPD     = 3'b100,
    SLPC_APD     = 3'b101,
    SLPC_PD_EXIT = 3'b110
  } slpc_state_t;
endpackage

// ### slpc_core.sv
// low-power state control of the sdram device
//
// What this block does
// - decode self refresh entry on command pins
// - clock-gate high with deselect exits self refresh
// - mode bit four[9] selects self refresh abort
// - abort cancels refresh, counter not advanced
// - command latency adds three clocks to exits
// - nop exit needs parity/latency/geardown off
// - clock-gate low with deselect enters power-down
// - running row operation finishes before power-down
// - closed banks precharge pd, else active pd
// - power-down disables buffers except clock/gate/reset
// - term disable bit gates termination input
// - power-down receivers off only after four-clock window; self refresh entry turns them off at once
// - loop stays on; any command after exit latency
// - reset low in power-down forces reset
// - clock-gate high with deselect exits power-down
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module slpc_core
  import slpc_pkg::*;
#(
  parameter int unsigned SR_EXIT_CYC = SR_EXIT_DELAY_CYC
)
(
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  input  wire  logic              cs_n,
  input  wire  logic              act_n,
  input  wire  logic              ras_n,
  input  wire  logic              cas_n,
  input  wire  logic              we_n,
  input  wire  logic              clock_gate,
  input  wire  logic              termination_control_input,
  input  wire  logic              row_op,
  input  wire  logic [NBANK-1:0]  bank_open,
  input  wire  logic [3:0]        awaddr,
  input  wire  logic              awvalid,
  output logic                    awready,
  input  wire  logic [31:0]       wdata,
  input  wire  logic [3:0]        wstrb,
  input  wire  logic              wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire  logic              bready,
  input  wire  logic [3:0]        araddr,
  input  wire  logic              arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire  logic              rready,
  output logic [2:0]              lp_state,
  output logic                    buffers_on,
  output logic                    receivers_on,
  output logic                    term_sampled,
  output logic                    cmd_ready,
  output logic                    refresh_abort,
  output logic                    nop_exit_ok
);
  initial
  begin
    if (SR_EXIT_CYC + CMD_LAT_CYC >= (1 << CNT_W)) $error("exit delay too long for counter");
  end

  slpc_state_t       st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [3:0]        ctrl_q, ctrl_d;
  logic              mr4_abort_q, mr4_abort_d;
  logic              mr5_tdis_q, mr5_tdis_d;
  logic              buf_q, buf_d, rcv_q, rcv_d, term_q, term_d;
  logic              rdy_q, rdy_d, abrt_q, abrt_d, nop_q, nop_d;
  logic              aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic              ws_q, ws_d;
  logic [3:0]        awa_q, awa_d;
  logic [31:0]       wd_q, wd_d, rd_q, rd_d;
  logic [1:0]        br_q, br_d, rr_q, rr_d;
  logic              desel, sre_cmd, exit_ev, lat_cal;
  logic [CNT_W-1:0]  lat_add;

  assign desel   = cs_n;
  assign sre_cmd = !cs_n && !ras_n && !cas_n && !clock_gate && we_n && act_n;
  assign exit_ev = clock_gate && desel;
  assign lat_cal = ctrl_q[CTRL_CAL];
  assign lat_add = lat_cal ? CNT_W'(CMD_LAT_CYC) : '0;

  // axi-lite slave: one write, one read in flight
  always_comb
  begin
    aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; ws_d = ws_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rr_d = rr_q; rd_d = rd_q;
    ctrl_d = ctrl_q;
    if (awvalid && !aw_q && !bv_q)
    begin
      aw_d = 1'b1; awa_d = awaddr;
    end
    if (wvalid && !w_q && !bv_q)
    begin
      w_d = 1'b1; wd_d = wdata; ws_d = wstrb[0];
    end
    if (aw_q && w_q)
    begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1;
      br_d = (awa_q == ADDR_CTRL) ? RESP_OKAY : RESP_SLV;
      if (awa_q == ADDR_CTRL && ws_q) ctrl_d = wd_q[3:0];
    end
    if (bv_q && bready) bv_d = 1'b0;
    if (arvalid && !rv_q)
    begin
      rv_d = 1'b1; rr_d = RESP_OKAY; rd_d = '0;
      case (araddr)
        ADDR_CTRL: rd_d = {28'h0000000, ctrl_q};
        ADDR_STAT: rd_d = {24'h000000, nop_q, abrt_q, rdy_q, rcv_q, buf_q, st_q};
        default:   rr_d = RESP_SLV;
      endcase
    end
    else if (rv_q && rready) rv_d = 1'b0;
  end
  // byte enable captured with the data beat; the master may drop it once taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 4'h0; wd_q <= 32'h00000000;
      bv_q <= 1'b0; br_q <= RESP_OKAY; rv_q <= 1'b0; rr_q <= RESP_OKAY;
      rd_q <= 32'h00000000; ctrl_q <= CTRL_RESET; ws_q <= 1'b0;
    end
    else
    begin
      aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rr_q <= rr_d;
      rd_q <= rd_d; ctrl_q <= ctrl_d; ws_q <= ws_d;
    end
  end
  assign awready = !aw_q && !bv_q;
  assign wready  = !w_q && !bv_q;
  assign bvalid  = bv_q;
  assign bresp   = br_q;
  assign arready = !rv_q;
  assign rvalid  = rv_q;
  assign rresp   = rr_q;
  assign rdata   = rd_q;

  // low-power state machine
  always_comb
  begin
    st_d = st_q; cnt_d = cnt_q;
    mr4_abort_d = ctrl_q[CTRL_ABORT];
    mr5_tdis_d  = ctrl_q[CTRL_TDIS];
    buf_d = buf_q; rcv_d = rcv_q; rdy_d = rdy_q; abrt_d = 1'b0;
    nop_d = !ctrl_q[CTRL_PARGD] && !lat_cal;
    term_d = term_q;
    case (st_q)
      SLPC_IDLE:
      begin
        rdy_d = 1'b1;
        if (sre_cmd)
        begin
          st_d = SLPC_SREF; rdy_d = 1'b0; buf_d = 1'b0; rcv_d = 1'b0;
        end
        else if (!clock_gate && desel)
        begin
          st_d = SLPC_PD_WIN; rdy_d = 1'b0; cnt_d = CNT_W'(DESEL_WIN_CYC - 1);
        end
      end
      SLPC_SREF:
        if (exit_ev)
        begin
          st_d = SLPC_SR_EXIT; buf_d = 1'b1; rcv_d = 1'b1;
          abrt_d = mr4_abort_q;
          cnt_d = (mr4_abort_q ? CNT_W'(SR_ABORT_DELAY_CYC) : CNT_W'(SR_EXIT_CYC)) + lat_add - 1'b1;
        end
      SLPC_SR_EXIT:
        if (cnt_q == '0) st_d = SLPC_IDLE;
        else cnt_d = cnt_q - 1'b1;
      SLPC_PD_WIN:
        if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
        else if (!row_op)
        begin
          st_d = (|bank_open) ? SLPC_APD : SLPC_PPD;
          buf_d = 1'b0; rcv_d = 1'b0;
        end
      SLPC_PPD, SLPC_APD:
        if (exit_ev)
        begin
          st_d = SLPC_PD_EXIT; buf_d = 1'b1; rcv_d = 1'b1;
          cnt_d = CNT_W'(PD_EXIT_LAT_CYC - 1) + lat_add;
        end
      SLPC_PD_EXIT:
        if (cnt_q == '0) st_d = SLPC_IDLE;
        else cnt_d = cnt_q - 1'b1;
      default: st_d = SLPC_IDLE;
    endcase
    if ((st_q == SLPC_PPD || st_q == SLPC_APD) && mr5_tdis_q) term_d = 1'b0;
    else term_d = termination_control_input;
  end
  // reset wins in any state, including power-down
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= SLPC_IDLE; cnt_q <= '0; mr4_abort_q <= 1'b0; mr5_tdis_q <= 1'b0;
      buf_q <= 1'b1; rcv_q <= 1'b1; term_q <= 1'b0; rdy_q <= 1'b0;
      abrt_q <= 1'b0; nop_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; cnt_q <= cnt_d; mr4_abort_q <= mr4_abort_d; mr5_tdis_q <= mr5_tdis_d;
      buf_q <= buf_d; rcv_q <= rcv_d; term_q <= term_d; rdy_q <= rdy_d;
      abrt_q <= abrt_d; nop_q <= nop_d;
    end
  end
  assign lp_state      = st_q;
  assign buffers_on    = buf_q;
  assign receivers_on  = rcv_q;
  assign term_sampled  = term_q;
  assign cmd_ready     = rdy_q;
  assign refresh_abort = abrt_q;
  assign nop_exit_ok   = nop_q;

  property p_sre;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_IDLE && sre_cmd) |=> st_q == SLPC_SREF;
  endproperty
  a_sre: assert property (p_sre) else $error("self refresh entry missed");
  property p_srx;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_SREF && exit_ev) |=> st_q == SLPC_SR_EXIT;
  endproperty
  a_srx: assert property (p_srx) else $error("self refresh exit missed");
  property p_abort;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_SREF && exit_ev) |=> refresh_abort == $past(mr4_abort_q);
  endproperty
  a_abort: assert property (p_abort) else $error("abort flag wrong");
  property p_pde;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_IDLE && !sre_cmd && !clock_gate && desel) |=> st_q == SLPC_PD_WIN;
  endproperty
  a_pde: assert property (p_pde) else $error("power-down entry missed");
  property p_win;
    @(posedge aclk) disable iff (!aresetn) $rose(st_q == SLPC_PD_WIN) |-> receivers_on [*4];
  endproperty
  a_win: assert property (p_win) else $error("receivers off too early");
  property p_bank;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == SLPC_PD_WIN && cnt_q == '0 && !row_op) |=> st_q == ($past(|bank_open) ? SLPC_APD : SLPC_PPD);
  endproperty
  a_bank: assert property (p_bank) else $error("wrong power-down kind");
  property p_row;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_PD_WIN && row_op) |=> st_q == SLPC_PD_WIN;
  endproperty
  a_row: assert property (p_row) else $error("entered low power too early");
  property p_buf;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_PPD || st_q == SLPC_APD) |-> !buffers_on;
  endproperty
  a_buf: assert property (p_buf) else $error("buffers on in power-down");
  property p_pdx;
    @(posedge aclk) disable iff (!aresetn)
      ((st_q == SLPC_PPD || st_q == SLPC_APD) && exit_ev && !lat_cal) |=> ##3 st_q == SLPC_IDLE;
  endproperty
  a_pdx: assert property (p_pdx) else $error("power-down exit latency wrong");
  property p_rst;
    @(posedge aclk) !aresetn |=> st_q == SLPC_IDLE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset did not clear state");

  // termination, buffer, window, busy, ready and exit-length checks on the registered state
  property p_term;
    @(posedge aclk) disable iff (!aresetn) ((st_q == SLPC_PPD || st_q == SLPC_APD) && mr5_tdis_q) |=> !term_sampled;
  endproperty
  a_term: assert property (p_term) else $error("termination not gated in power-down");
  property p_srbuf;
    @(posedge aclk) disable iff (!aresetn) st_q == SLPC_SREF |-> !buffers_on && !receivers_on;
  endproperty
  a_srbuf: assert property (p_srbuf) else $error("buffers on in self refresh");
  property p_desel;
    @(posedge aclk) disable iff (!aresetn) st_q == SLPC_PD_WIN |-> buffers_on && receivers_on;
  endproperty
  a_desel: assert property (p_desel) else $error("receivers off inside deselect window");
  property p_busy;
    @(posedge aclk) disable iff (!aresetn) st_q != SLPC_IDLE |-> !cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("commands accepted outside idle");
  property p_ready;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_IDLE && clock_gate) |=> cmd_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("idle without command ready");
  property p_srlen;
    @(posedge aclk) disable iff (!aresetn) (st_q == SLPC_SREF && exit_ev && !mr4_abort_q && !lat_cal)
      |=> st_q == SLPC_SR_EXIT && cnt_q == CNT_W'(SR_EXIT_CYC - 1);
  endproperty
  a_srlen: assert property (p_srlen) else $error("self refresh exit delay wrong");
  property p_pdcal;
    @(posedge aclk) disable iff (!aresetn)
      ((st_q == SLPC_PPD || st_q == SLPC_APD) && exit_ev && lat_cal) |=> ##6 st_q == SLPC_IDLE;
  endproperty
  a_pdcal: assert property (p_pdcal) else $error("latency-mode exit delay wrong");
endmodule
`default_nettype wire

// ### slpc_host_model.sv
// host controller model that drives the command pins of the low-power block
`timescale 1ns/100ps
`default_nettype none
module slpc_host_model
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       go,
  input  wire logic [1:0] op,
  input  wire logic       float_en,
  output logic            cs_n,
  output logic            act_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic            clock_gate,
  output logic            termination_control_input
);
  always_ff @(posedge aclk)
  begin
    // deselected pins carry no meaning, so they toggle every cycle
    // only deselects between strobed commands, so exit windows see nothing else
    // no loop is left unlocked here, so no loop reset is owed after an exit
    {act_n, ras_n, cas_n, we_n} <= ~{act_n, ras_n, cas_n, we_n};
    cs_n <= 1'b1;
    // valid level unless the buffer disable lets the pin float
    termination_control_input <= float_en ? ~termination_control_input : 1'b1;
    if (!aresetn)
    begin
      {act_n, ras_n, cas_n, we_n} <= 4'hA;
      clock_gate <= 1'b1;
      termination_control_input <= 1'b1;
    end
    else if (go && op == 2'h1)
    begin
      {cs_n, act_n, ras_n, cas_n, we_n} <= 5'h09; // self refresh entry code
      clock_gate <= 1'b0;
    end
    else if (go && op == 2'h0)
      {cs_n, act_n, ras_n, cas_n, we_n} <= 5'h09; // refresh, gate high, owed before re-entry
    else if (go)
      clock_gate <= (op == 2'h3); // gate moves only under deselect
  end
endmodule
`default_nettype wire

// ### slpc_core_tb.sv
// self-checking bench for the sdram low-power state control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t got %0h", $time, a); end end
module slpc_core_tb;
  import slpc_pkg::*;
  localparam int unsigned SR_X = 2;
  logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, float_en = 1'b0, row_op = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [15:0] bank_open = 16'h0;
  logic        cs_n, act_n, ras_n, cas_n, we_n, clock_gate, termination_control_input;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [2:0]  lp_state;
  logic        buffers_on, receivers_on, term_sampled, cmd_ready, refresh_abort, nop_exit_ok;
  logic [3:0]  ctl;
  int          n_fail = 0, n_compared = 0, n_abort = 0, c;

  slpc_host_model host_u (.aclk, .aresetn, .go, .op, .float_en, .cs_n, .act_n, .ras_n, .cas_n, .we_n,
                          .clock_gate, .termination_control_input);
  slpc_core #(.SR_EXIT_CYC(SR_X)) dut_u (.aclk, .aresetn, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .clock_gate,
    .termination_control_input, .row_op, .bank_open, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .lp_state, .buffers_on, .receivers_on, .term_sampled, .cmd_ready, .refresh_abort, .nop_exit_ok);

  always #20 aclk = ~aclk;
  always @(posedge aclk)
    if (refresh_abort === 1'b1)
      n_abort++;

  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    // bready stays up between calls: only the watchdog ends a wait
    `CHK(bresp, er)
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
    `CHK(rresp, er)
  endtask

  task automatic cmd(input logic [1:0] o);
    op <= o;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  // counts cycles spent in one state over a fixed span
  task automatic cnt(input logic [2:0] s, input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge aclk);
      if (lp_state === s)
        k++;
    end
  endtask

  initial
  begin
    repeat (3000) @(posedge aclk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({buffers_on, receivers_on, lp_state}, {2'b11, SLPC_IDLE})
    axi_rd(ADDR_CTRL, d, RESP_OKAY);
    `CHK(d[3:0], CTRL_RESET)
    axi_rd(ADDR_STAT, d, RESP_OKAY);
    `CHK(d[7:0], {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, SLPC_IDLE})
    axi_wr(4'h8, 32'hF, RESP_SLV);
    axi_rd(4'hC, d, RESP_SLV);
    $display("register test done");
    // abort off, abort on, latency plus parity on
    for (int i = 0; i < 3; i++)
    begin
      ctl = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'hC;
      axi_wr(ADDR_CTRL, {28'h0, ctl}, RESP_OKAY);
      n_abort = 0;
      cmd(2'h1);
      repeat (4) @(posedge aclk);
      `CHK({lp_state, cmd_ready}, {SLPC_SREF, 1'b0})
      `CHK(nop_exit_ok, ~ctl[CTRL_CAL] & ~ctl[CTRL_PARGD])
      cmd(2'h3);
      cnt(SLPC_SR_EXIT, 30, c);
      `CHK(c, (ctl[CTRL_ABORT] ? SR_ABORT_DELAY_CYC : SR_X) + (ctl[CTRL_CAL] ? CMD_LAT_CYC : 0))
      `CHK(n_abort, int'(ctl[CTRL_ABORT]))
      `CHK({lp_state, cmd_ready}, {SLPC_IDLE, 1'b1})
      cmd(2'h0);
      $display("self refresh test %0d done", i);
    end
    // precharge pd with buffer on; active pd with latency, float and a running row op
    for (int j = 0; j < 2; j++)
    begin
      axi_wr(ADDR_CTRL, j ? 32'h6 : 32'h0, RESP_OKAY);
      bank_open <= j ? 16'h0001 : 16'h0000;
      row_op    <= j[0];
      cmd(2'h2);
      // first edge of the span still shows idle
      cnt(SLPC_PD_WIN, 11, c);
      `CHK(c, j ? 10 : DESEL_WIN_CYC)
      row_op   <= 1'b0;
      float_en <= j[0]; // pin floats only after the deselect window
      repeat (4) @(posedge aclk);
      `CHK(lp_state, j ? SLPC_APD : SLPC_PPD)
      `CHK({buffers_on, receivers_on}, 2'b00)
      `CHK(term_sampled, ~j[0])
      float_en <= 1'b0;
      cmd(2'h3);
      cnt(SLPC_PD_EXIT, 20, c);
      `CHK(c, PD_EXIT_LAT_CYC + (j ? CMD_LAT_CYC : 0))
      `CHK({lp_state, cmd_ready}, {SLPC_IDLE, 1'b1})
      $display("power-down test %0d done", j);
    end
    cmd(2'h2);
    repeat (8) @(posedge aclk);
    `CHK(lp_state, SLPC_APD)
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK({lp_state, buffers_on}, {SLPC_IDLE, 1'b1})
    $display("reset in power-down test done");
    test_done();
  end
endmodule
`default_nettype wire
